// File: flash_host_defines.svh
// constants for the parallel flash guard and suspend host controller
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// apb register offsets (byte addresses)
`define REG_COMMAND 8'h00
`define REG_ADDRESS 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10
`define REG_MODE 8'h14

// host status register bit positions
`define STAT_BUSY 0
`define STAT_SUSPENDED 1
`define STAT_NOT_BLANK 2
`define STAT_REFUSED 3
`define STAT_PROG_FAIL 4
`define STAT_OVERLAY 5
`define STAT_TIMEOUT 6
`define STAT_RESUME_DUE 7

// flash command codes and addresses
`define CMD_SUSPEND 16'h00B0
`define CMD_RESUME 16'h0030
`define CMD_BLANK_CHECK 16'h0033
`define CMD_STATUS_READ 16'h0070
`define CMD_CLEAR_STATUS 16'h0071
`define UNLOCK_OFFSET 16'h0555
`define SECTOR_HI 23
`define SECTOR_LO 16

// flash status word bit positions
`define FST_READY 7
`define FST_ERASE_SUSP 6
`define FST_ERASE_FAIL 5
`define FST_PROG_FAIL 4

// lock register fields; every other bit is reserved and written as one
`define LOCK_CUST_SSR 6
`define LOCK_PROT_MODE 1
`define LOCK_FACT_SSR 0
`define LOCK_FIELD_MASK 16'h0043

// timing
`define CLK_NS 20
`define WE_LOW_NS 35
`define OE_ACCESS_NS 100
`define RECOVER_NS 30
`define WE_LOW_CYC ((`WE_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define OE_ACCESS_CYC ((`OE_ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define RECOVER_CYC ((`RECOVER_NS + `CLK_NS - 1) / `CLK_NS)
`define POLL_LIMIT_DEFAULT 200000

`endif

// File: flash_host_pkg.sv
// types shared by the flash host controller modules
package flash_host_pkg;

    // pins driven toward the flash
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dq_o;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } flash_pins_t;

    // operations software may start
    typedef enum logic [3:0] {
        OP_WRITE,
        OP_READ,
        OP_SUSPEND,
        OP_RESUME,
        OP_BLANK,
        OP_STATUS,
        OP_CLEAR,
        OP_LOCK_PROG
    } op_t;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CMD,
        ST_POLL_CMD,
        ST_POLL_RD,
        ST_READ
    } seq_state_t;

    // single bus cycle states
    typedef enum logic [1:0] {
        CY_IDLE,
        CY_SETUP,
        CY_STROBE,
        CY_RECOVER
    } cyc_state_t;

endpackage

// File: flash_bus_cycle.sv
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/100ps
`include "flash_host_defines.svh"

module flash_bus_cycle (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic req_write,
    input wire logic [23:0] req_addr,
    input wire logic [15:0] req_data,
    output logic done,
    output logic [15:0] rd_data,
    output flash_host_pkg::flash_pins_t pins,
    input wire logic [15:0] dq_i
);
    import flash_host_pkg::*;

    cyc_state_t state_reg;
    logic write_reg;
    logic [3:0] count_reg;

    // cycle sequencing: setup, strobe low for the timed width, recover
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= CY_IDLE;
            write_reg <= 1'b0;
            count_reg <= 4'h0;
            done <= 1'b0;
            rd_data <= 16'h0000;
            pins <= '{addr: 24'h000000, dq_o: 16'h0000, dq_oe: 1'b0,
                      ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        end
        else
        begin
            done <= 1'b0;
            case (state_reg)
                CY_IDLE:
                begin
                    if (req)
                    begin
                        write_reg <= req_write;
                        pins.addr <= req_addr;
                        pins.dq_o <= req_data;
                        pins.dq_oe <= req_write;
                        pins.ce_n <= 1'b0;
                        state_reg <= CY_SETUP;
                    end
                end
                CY_SETUP:
                begin
                    pins.we_n <= ~write_reg;
                    pins.oe_n <= write_reg;
                    count_reg <= write_reg ? 4'(`WE_LOW_CYC) : 4'(`OE_ACCESS_CYC);
                    state_reg <= CY_STROBE;
                end
                CY_STROBE:
                begin
                    if (count_reg <= 4'h1)
                    begin
                        if (!write_reg)
                            rd_data <= dq_i;
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                        count_reg <= 4'(`RECOVER_CYC);
                        state_reg <= CY_RECOVER;
                    end
                    else
                        count_reg <= count_reg - 4'h1;
                end
                CY_RECOVER:
                begin
                    pins.ce_n <= 1'b1;
                    pins.dq_oe <= 1'b0;
                    if (count_reg <= 4'h1)
                    begin
                        done <= 1'b1;
                        state_reg <= CY_IDLE;
                    end
                    else
                        count_reg <= count_reg - 4'h1;
                end
                default:
                    state_reg <= CY_IDLE;
            endcase
        end
    end

endmodule // flash_bus_cycle

// File: flash_guard_host.sv
// apb-controlled host for flash erase suspend, blank check and guard commands
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "flash_host_defines.svh"

module flash_guard_host #(
    parameter int POLL_LIMIT = `POLL_LIMIT_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output flash_host_pkg::flash_pins_t flash_pins,
    input wire logic [15:0] flash_dq_i
);
    import flash_host_pkg::*;

    // register decode, used by read and write paths
    function automatic logic addr_mapped(input logic [31:0] a);
        addr_mapped = (a[31:8] == 24'h000000) && (a[1:0] == 2'b00) &&
            (a[7:0] <= `REG_MODE);
    endfunction

    seq_state_t state_reg;
    op_t op_reg;
    logic [23:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic overlay_reg;
    logic suspended_reg;
    logic not_blank_reg;
    logic refused_reg;
    logic prog_fail_reg;
    logic resume_due_reg;
    logic timeout_reg;
    logic [17:0] poll_count_reg;
    logic cyc_req_reg;
    logic cyc_write_reg;
    logic [23:0] cyc_addr_reg;
    logic [15:0] cyc_data_reg;
    logic cyc_done;
    logic [15:0] cyc_rd_data;
    logic apb_write;
    logic start_ok;
    op_t new_op;
    logic [7:0] status_word;
    logic [17:0] poll_limit_cyc;

    assign poll_limit_cyc = 18'(POLL_LIMIT);
    assign apb_write = psel && penable && pready && pwrite && addr_mapped(paddr);
    assign new_op = op_t'(pwdata[3:0]);
    assign status_word = {resume_due_reg, timeout_reg, overlay_reg, prog_fail_reg,
                          refused_reg, not_blank_reg, suspended_reg,
                          (state_reg != ST_IDLE)};

    // host-side admission of a new operation
    always_comb
    begin
        case (new_op)
            OP_SUSPEND:
                start_ok = !overlay_reg;
            OP_RESUME:
                start_ok = !overlay_reg && suspended_reg;
            OP_BLANK:
                start_ok = !suspended_reg && !resume_due_reg;
            OP_WRITE, OP_LOCK_PROG:
                start_ok = !prog_fail_reg && !resume_due_reg;
            OP_READ, OP_STATUS, OP_CLEAR:
                start_ok = 1'b1;
            default:
                start_ok = 1'b0;
        endcase
    end

    // apb answer: registered data and a one-cycle ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pready <= 1'b1;
            pslverr <= !addr_mapped(paddr);
            case (paddr[7:0])
                `REG_ADDRESS: prdata <= {8'h00, addr_reg};
                `REG_WDATA: prdata <= {16'h0000, wdata_reg};
                `REG_STATUS: prdata <= {24'h000000, status_word};
                `REG_RDATA: prdata <= {16'h0000, rdata_reg};
                `REG_MODE: prdata <= {31'h00000000, overlay_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // software-written address, data and overlay mode flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_reg <= 24'h000000;
            wdata_reg <= 16'h0000;
            overlay_reg <= 1'b0;
        end
        else if (apb_write)
        begin
            if (paddr[7:0] == `REG_ADDRESS)
                addr_reg <= pwdata[23:0];
            if (paddr[7:0] == `REG_WDATA)
                wdata_reg <= pwdata[15:0];
            if (paddr[7:0] == `REG_MODE && !(pwdata[0] && suspended_reg))
                overlay_reg <= pwdata[0];
        end
    end

    // operation sequencer: command write, then status polling until ready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_IDLE;
            op_reg <= OP_READ;
            cyc_req_reg <= 1'b0;
            cyc_write_reg <= 1'b0;
            cyc_addr_reg <= 24'h000000;
            cyc_data_reg <= 16'h0000;
            poll_count_reg <= 18'h00000;
            refused_reg <= 1'b0;
            timeout_reg <= 1'b0;
        end
        else
        begin
            cyc_req_reg <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    if (apb_write && paddr[7:0] == `REG_COMMAND)
                    begin
                        refused_reg <= !start_ok;
                        timeout_reg <= 1'b0;
                        op_reg <= new_op;
                        poll_count_reg <= 18'h00000;
                        if (start_ok)
                        begin
                            cyc_req_reg <= 1'b1;
                            cyc_write_reg <= (new_op != OP_READ) && (new_op != OP_STATUS);
                            cyc_addr_reg <= addr_reg;
                            cyc_data_reg <= wdata_reg;
                            state_reg <= ST_CMD;
                            case (new_op)
                                OP_READ:
                                    state_reg <= ST_READ;
                                OP_STATUS:
                                begin
                                    cyc_write_reg <= 1'b1;
                                    cyc_addr_reg <= {8'h00, `UNLOCK_OFFSET};
                                    cyc_data_reg <= `CMD_STATUS_READ;
                                    state_reg <= ST_POLL_CMD;
                                end
                                OP_SUSPEND:
                                    cyc_data_reg <= `CMD_SUSPEND;
                                OP_RESUME:
                                    cyc_data_reg <= `CMD_RESUME;
                                OP_BLANK:
                                begin
                                    cyc_addr_reg <= {addr_reg[`SECTOR_HI:`SECTOR_LO],
                                                     `UNLOCK_OFFSET};
                                    cyc_data_reg <= `CMD_BLANK_CHECK;
                                end
                                OP_CLEAR:
                                begin
                                    cyc_addr_reg <= {8'h00, `UNLOCK_OFFSET};
                                    cyc_data_reg <= `CMD_CLEAR_STATUS;
                                end
                                OP_LOCK_PROG:
                                    cyc_data_reg <= wdata_reg | ~`LOCK_FIELD_MASK;
                                default:
                                    cyc_data_reg <= wdata_reg;
                            endcase
                        end
                    end
                end
                ST_CMD:
                begin
                    if (cyc_done)
                    begin
                        // suspend, resume, blank check and lock program wait for ready
                        if (op_reg == OP_SUSPEND || op_reg == OP_RESUME ||
                            op_reg == OP_BLANK || op_reg == OP_LOCK_PROG)
                        begin
                            cyc_req_reg <= 1'b1;
                            cyc_write_reg <= 1'b1;
                            cyc_addr_reg <= {8'h00, `UNLOCK_OFFSET};
                            cyc_data_reg <= `CMD_STATUS_READ;
                            state_reg <= ST_POLL_CMD;
                        end
                        else
                            state_reg <= ST_IDLE;
                    end
                end
                ST_POLL_CMD:
                begin
                    if (cyc_done)
                    begin
                        cyc_req_reg <= 1'b1;
                        cyc_write_reg <= 1'b0;
                        state_reg <= ST_POLL_RD;
                    end
                end
                ST_POLL_RD:
                begin
                    if (cyc_done)
                    begin
                        poll_count_reg <= poll_count_reg + 18'h00001;
                        if (cyc_rd_data[`FST_READY] || op_reg == OP_STATUS)
                            state_reg <= ST_IDLE;
                        else if (poll_count_reg + 18'h00001 >= poll_limit_cyc)
                        begin
                            timeout_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        else
                        begin
                            cyc_req_reg <= 1'b1;
                            cyc_write_reg <= 1'b1;
                            cyc_addr_reg <= {8'h00, `UNLOCK_OFFSET};
                            cyc_data_reg <= `CMD_STATUS_READ;
                            state_reg <= ST_POLL_CMD;
                        end
                    end
                end
                ST_READ:
                begin
                    if (cyc_done)
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // results taken from the ready status word or the array read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_reg <= 16'h0000;
            suspended_reg <= 1'b0;
            not_blank_reg <= 1'b0;
            prog_fail_reg <= 1'b0;
            resume_due_reg <= 1'b0;
        end
        else if (cyc_done && (state_reg == ST_READ || state_reg == ST_POLL_RD))
        begin
            rdata_reg <= cyc_rd_data;
            if (state_reg == ST_POLL_RD && cyc_rd_data[`FST_READY])
            begin
                suspended_reg <= cyc_rd_data[`FST_ERASE_SUSP];
                if (op_reg == OP_BLANK)
                    not_blank_reg <= cyc_rd_data[`FST_ERASE_FAIL];
                if (cyc_rd_data[`FST_ERASE_SUSP] && cyc_rd_data[`FST_PROG_FAIL])
                    prog_fail_reg <= 1'b1;
                if (op_reg == OP_RESUME)
                    resume_due_reg <= 1'b0;
            end
        end
        else if (cyc_done && state_reg == ST_CMD && op_reg == OP_CLEAR && prog_fail_reg)
        begin
            prog_fail_reg <= 1'b0;
            resume_due_reg <= 1'b1;
        end
    end

    flash_bus_cycle u_cycle (
        .pclk(pclk),
        .presetn(presetn),
        .req(cyc_req_reg),
        .req_write(cyc_write_reg),
        .req_addr(cyc_addr_reg),
        .req_data(cyc_data_reg),
        .done(cyc_done),
        .rd_data(cyc_rd_data),
        .pins(flash_pins),
        .dq_i(flash_dq_i)
    );

endmodule // flash_guard_host

// File: flash_guard_host_props.sv
// concurrent checks on the flash guard host ports
`timescale 1ns/100ps
`include "flash_host_defines.svh"

module flash_guard_host_props #(
    parameter int POLL_LIMIT = `POLL_LIMIT_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire flash_host_pkg::flash_pins_t flash_pins,
    input wire logic [15:0] flash_dq_i
);
    import flash_host_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // apb answer timing and error decode
    a_pready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");
    a_pready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup cycle");
    a_unmapped_err: assert property (pready && (paddr[31:8] != 24'h0 || paddr[1:0] != 2'h0
        || paddr[7:0] > 8'h14) |-> pslverr)
        else $error("unmapped access not flagged");
    a_mapped_no_err: assert property (pready && paddr == 32'h00000004 |-> !pslverr && prdata[31:24] == 8'h00)
        else $error("mapped access flagged or upper bits set");
    // flash strobe shapes and bus ownership
    a_read_no_drive: assert property (!flash_pins.oe_n |-> !flash_pins.dq_oe && !flash_pins.ce_n && flash_pins.we_n)
        else $error("read strobe while host drives data");
    a_write_pulse: assert property ($fell(flash_pins.we_n) |-> ##1 !flash_pins.we_n ##1 flash_pins.we_n)
        else $error("write strobe width wrong");
    a_write_drives: assert property (!flash_pins.we_n |-> flash_pins.dq_oe && !flash_pins.ce_n)
        else $error("write strobe without driven data");
    a_read_pulse: assert property ($fell(flash_pins.oe_n) |-> !flash_pins.oe_n [*5] ##1 flash_pins.oe_n)
        else $error("read strobe width wrong");
    a_addr_hold: assert property (!flash_pins.ce_n && $past(!flash_pins.ce_n)
        |-> $stable(flash_pins.addr) && $stable(flash_pins.dq_o))
        else $error("address or data moved inside a cycle");
    // main scenarios reached
    c_flash_write: cover property ($fell(flash_pins.we_n));
    c_flash_read: cover property ($fell(flash_pins.oe_n));
    c_apb_err: cover property (pready && pslverr);
endmodule // flash_guard_host_props

bind flash_guard_host flash_guard_host_props #(.POLL_LIMIT(POLL_LIMIT)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_pins(flash_pins), .flash_dq_i(flash_dq_i));

// File: flash_device_model.sv
// behavioural parallel flash: suspend, blank check, lock register
`timescale 1ns/100ps
`include "flash_host_defines.svh"

module flash_device_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire flash_host_pkg::flash_pins_t pins,
    input wire logic erase_go,
    input wire logic erase_chip,
    output logic [15:0] dq,
    output logic host_err
);
    import flash_host_pkg::*;
    localparam logic [7:0] ERASE_SECTOR = 8'h05;
    localparam logic [7:0] BLANK_SECTOR = 8'h02;
    logic we_q, oe_q, erasing, chip, suspended, stat_mode, fail4, fail5, tog, ready;
    logic [15:0] lock_q, last, a16;
    int busy, erase_left;
    assign ready = !erasing && busy == 0;
    assign a16 = pins.addr[15:0];

    // command decode at the rising write strobe
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {we_q, oe_q, erasing, chip, suspended, stat_mode, fail4, fail5, tog} <= 9'h180;
            {host_err, busy, erase_left, last} <= '0;
            lock_q <= 16'hFEFC;
        end
        else
        begin
            we_q <= pins.we_n;
            oe_q <= pins.oe_n;
            if (!pins.oe_n)
                last <= dq;
            if (busy > 0)
                busy <= busy - 1;
            if (erase_go)
                {erasing, chip, erase_left} <= {1'b1, erase_chip, erase_chip ? 32'd1000 : 32'd150};
            else if (erasing)
                {erasing, erase_left} <= {erase_left != 1, erase_left - 1};
            if (pins.oe_n && !oe_q)
                {stat_mode, tog} <= {1'b0, !tog};
            if (pins.we_n && !we_q)
            begin
                if (pins.dq_o == `CMD_STATUS_READ)
                    stat_mode <= 1'b1;
                else if (pins.dq_o == `CMD_CLEAR_STATUS)
                    {fail4, fail5} <= 2'b00;
                else if (pins.dq_o == `CMD_SUSPEND && erasing && !chip)
                    {suspended, erasing, busy} <= {2'b10, 32'd3};
                else if (pins.dq_o == `CMD_RESUME && suspended)
                    {suspended, erasing} <= 2'b01;
                else if (pins.dq_o == `CMD_BLANK_CHECK)
                begin
                    if (a16 != `UNLOCK_OFFSET)
                        host_err <= 1'b1;
                    else if (ready && !suspended)
                        {busy, fail5} <= {32'd8, pins.addr[23:16] != BLANK_SECTOR};
                end
                else if (pins.addr[23:16] == 8'hFF)
                begin
                    if ((pins.dq_o | `LOCK_FIELD_MASK) != 16'hFFFF)
                        host_err <= 1'b1;
                    {lock_q, busy} <= {lock_q & pins.dq_o, 32'd4};
                end
                else if (suspended)
                    {busy, fail4} <= {32'd3, pins.addr[23:16] == ERASE_SECTOR};
            end
        end
    end

    // read data; a released bus shows the inverse of the last word
    always_comb
    begin
        if (pins.oe_n || pins.ce_n)
            dq = ~last;
        else if (stat_mode)
            dq = {8'h00, ready, ready ? suspended : tog, fail5, fail4, 4'h0};
        else if (pins.addr[23:16] == 8'hFF)
            dq = lock_q;
        else if (!ready || (suspended && pins.addr[23:16] == ERASE_SECTOR))
            dq = ~(a16 ^ 16'hA5A5);
        else
            dq = a16 ^ 16'hA5A5;
    end
endmodule // flash_device_model

// File: erase_suspend_blank_check_protection_bench.sv
// self-checking bench for the flash guard and suspend host
`timescale 1ns/100ps
`include "flash_host_defines.svh"

module erase_suspend_blank_check_protection_bench;
    import flash_host_pkg::*;
    typedef struct packed { logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic err; } row_t;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, host_err, er;
    logic erase_go = 0;
    logic erase_chip = 0;
    flash_pins_t flash_pins;
    logic [15:0] flash_dq_i;
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;
    row_t rows [11] = '{'{8'h0C, 0, 0, 0, 0}, '{8'h04, 1, 32'h00123456, 0, 0},
        '{8'h04, 0, 0, 32'h00123456, 0}, '{8'h08, 1, 32'h0001BEEF, 0, 0},
        '{8'h08, 0, 0, 32'h0000BEEF, 0}, '{8'h14, 1, 1, 0, 0}, '{8'h14, 0, 0, 1, 0},
        '{8'h14, 1, 0, 0, 0}, '{8'h00, 0, 0, 0, 0}, '{8'h18, 0, 0, 0, 1}, '{8'h06, 1, 5, 0, 1}};

    flash_guard_host #(.POLL_LIMIT(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flash_pins(flash_pins), .flash_dq_i(flash_dq_i));
    flash_device_model flash (.pclk(pclk), .presetn(presetn), .pins(flash_pins),
        .erase_go(erase_go), .erase_chip(erase_chip), .dq(flash_dq_i), .host_err(host_err));

    // clock
    initial
    begin
        forever #10 pclk = ~pclk;
    end

    task automatic test_done;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; waits for pready at a rising edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 24'h0, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    // start an operation and poll until the host is no longer busy
    task automatic cmd(input logic [3:0] op);
        apb(`REG_COMMAND, 1'b1, {28'h0, op});
        for (int i = 0; i < 3000; i++)
        begin
            apb(`REG_STATUS, 1'b0, 0);
            if (rd[`STAT_BUSY] === 1'b0)
                break;
        end
    endtask

    task automatic st(input logic [31:0] mask, input logic [31:0] exp, input string name);
        apb(`REG_STATUS, 1'b0, 0);
        chk(name, exp, rd & mask);
    endtask

    task automatic go;
        @(posedge pclk);
        erase_go <= 1'b1;
        @(posedge pclk);
        erase_go <= 1'b0;
    endtask

    // cycle ceiling
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_fail++;
            test_done();
        end
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // register table rows
        for (int k = 0; k < 11; k++)
        begin
            apb(rows[k].a, rows[k].w, rows[k].d);
            chk("pslverr", {31'h0, rows[k].err}, {31'h0, er});
            if (!rows[k].w)
                chk("prdata", rows[k].e, rd);
        end
        // lock register: program, then try to undo
        apb(`REG_ADDRESS, 1'b1, 32'h00FF0000);
        for (int k = 0; k < 2; k++)
        begin
            apb(`REG_WDATA, 1'b1, k ? 32'h0000FFFF : 32'h0);
            cmd(OP_LOCK_PROG);
            cmd(OP_READ);
            apb(`REG_RDATA, 1'b0, 0);
            chk("lock word", 32'h0000FEBC, rd);
        end
        // blank check on a dirty and a clean sector
        for (int k = 0; k < 2; k++)
        begin
            apb(`REG_ADDRESS, 1'b1, {8'h0, k ? 8'h02 : 8'h03, 16'h1234});
            cmd(OP_BLANK);
            st(32'h4, k ? 32'h0 : 32'h4, "not blank");
        end
        // suspend a sector erase, read inside and outside
        go();
        cmd(OP_SUSPEND);
        st(32'h2, 32'h2, "suspended");
        for (int k = 0; k < 2; k++)
        begin
            apb(`REG_ADDRESS, 1'b1, {8'h0, k ? 8'h06 : 8'h05, 16'h0042});
            cmd(OP_READ);
            apb(`REG_RDATA, 1'b0, 0);
            chk("array read", {16'h0, k ? 16'hA5E7 : 16'h5A18}, rd);
        end
        apb(`REG_MODE, 1'b1, 1);
        apb(`REG_MODE, 1'b0, 0);
        chk("overlay", 0, rd);
        cmd(OP_BLANK);
        st(32'h8, 32'h8, "blank refused");
        // program into the suspended sector fails, then recovery
        apb(`REG_ADDRESS, 1'b1, 32'h00050010);
        apb(`REG_WDATA, 1'b1, 32'h1234);
        cmd(OP_WRITE);
        cmd(OP_STATUS);
        st(32'h12, 32'h12, "program fail");
        cmd(OP_CLEAR);
        st(32'h92, 32'h82, "cleared");
        cmd(OP_WRITE);
        st(32'h8, 32'h8, "write refused");
        cmd(OP_RESUME);
        st(32'hC2, 32'h0, "resumed");
        cmd(OP_RESUME);
        st(32'h8, 32'h8, "resume refused");
        chk("host error", 0, {31'h0, host_err});
        // suspend during chip erase is ignored, host times out
        erase_chip <= 1'b1;
        go();
        cmd(OP_SUSPEND);
        st(32'h42, 32'h40, "chip erase timeout");
        // mid-run reset clears status and idles the strobes
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        st(32'hFF, 32'h0, "status after reset");
        chk("ce_n idle", 1, {31'h0, flash_pins.ce_n});
        test_done();
    end
endmodule // erase_suspend_blank_check_protection_bench
